// ### bench/reg_file_model.sv
// Behavioural register file and stack write recorder facing the stack sequencer.
`default_nettype none
module reg_file_model (
  input  wire logic        clock,
  input  wire logic [7:0]  rf_raddr,
  output logic      [7:0]  rf_rdata,
  input  wire logic        rf_we,
  input  wire logic [7:0]  rf_waddr,
  input  wire logic [7:0]  rf_wdata,
  input  wire logic        stk_we,
  input  wire logic [15:0] stk_addr,
  input  wire logic [7:0]  stk_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  regs [256];
  logic [15:0] stk_addr_seen;
  logic [7:0]  stk_data_seen;
  int          stk_writes;
  // pointers and stacks here.
  // Reads are asynchronous because the sequencer samples data in the same cycle.
  assign rf_rdata = regs[rf_raddr];
  always @(posedge clock) begin
    if (rf_we === 1'b1) begin
      regs[rf_waddr] <= rf_wdata;
    end
    if (stk_we === 1'b1) begin
      stk_addr_seen <= stk_addr;
      stk_data_seen <= stk_wdata;
      stk_writes    <= stk_writes + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/stack_push_pop_exec_test.sv
// Self-checking bench for the stack instruction sequencer.
`default_nettype none
module stack_push_pop_exec_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        start = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [7:0]  opnd1 = 8'h00;
  logic [7:0]  opnd2 = 8'h00;
  logic        busy, done, rf_we, stk_we, flags_we;
  logic [1:0]  instr_bytes;
  logic [7:0]  rf_raddr, rf_rdata, rf_waddr, rf_wdata, stk_wdata;
  logic [15:0] stk_addr;
  logic [7:0]  wr_log [$];
  logic        flag_seen = 1'b0;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #10 clock = ~clock;

  stack_push_pop_exec uut (.clock(clock), .rst_n(rst_n), .ce(ce), .start(start),
    .opcode(opcode), .opnd1(opnd1), .opnd2(opnd2), .busy(busy), .done(done),
    .instr_bytes(instr_bytes), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
    .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .stk_we(stk_we), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .flags_we(flags_we));

  reg_file_model model (.clock(clock), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .stk_we(stk_we),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata));

  always @(posedge clock) begin
    if (rf_we === 1'b1) begin
      wr_log.push_back(rf_waddr);
    end
    if (flags_we !== 1'b0) begin
      flag_seen <= 1'b1;
    end
  end

  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Launches one instruction, optionally stalls ce or pokes a second start, then
  // checks length, byte count and the order of the two register-file writes.
  task automatic run_op(input logic [7:0] opc, input logic [7:0] o1, input logic [7:0] o2,
                        input int stall, input bit poke, input logic [1:0] nbytes,
                        input logic [7:0] w0, input logic [7:0] w1);
    int n;
    wr_log.delete();
    opcode = opc;
    opnd1  = o1;
    opnd2  = o2;
    start  = 1'b1;
    @(posedge clock);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      if (n == 40) begin
        n_errors++;
        test_done();
      end
      @(posedge clock);
      #1;
      n++;
      start = poke && (n == 3);
      opcode = (n == 3) ? 8'h83 : opc;
      if (n == 2) ce = (stall == 0);
      if (n == 2 + stall) ce = 1'b1;
    end
    chk("cycles", 16'(8 + stall), 16'(n));
    chk("instr_bytes", 16'(nbytes), 16'(instr_bytes));
    chk("write count", 16'h0002, 16'(wr_log.size()));
    chk("first waddr", {8'h00, w0}, {8'h00, wr_log[0]});
    chk("second waddr", {8'h00, w1}, {8'h00, wr_log[1]});
    chk("flags_we", 16'h0000, {15'h0000, flag_seen});
  endtask

  function automatic logic [15:0] rd(input logic [7:0] a);
    return {8'h00, model.regs[a]};
  endfunction

  task automatic pop_dec_with_busy_start();
    model.regs[8'h00] = 8'h42;
    model.regs[8'h42] = 8'h6F;
    model.regs[8'h02] = 8'h70;
    run_op(8'h92, 8'h00, 8'h02, 0, 1'b1, 2'h3, 8'h02, 8'h00);
    @(posedge clock);
    #1;
    chk("pop dst", 16'h006F, rd(8'h02));
    chk("pop ptr", 16'h0041, rd(8'h00));
  endtask

  task automatic pop_inc_wrap_stall();
    model.regs[8'h10] = 8'hFF;
    model.regs[8'hFF] = 8'h5A;
    model.regs[8'h11] = 8'h33;
    run_op(8'h93, 8'h10, 8'h20, 3, 1'b0, 2'h3, 8'h20, 8'h10);
    @(posedge clock);
    #1;
    chk("pop dst", 16'h005A, rd(8'h20));
    chk("pop ptr", 16'h0000, rd(8'h10));
    chk("neighbour", 16'h0033, rd(8'h11));
  endtask

  task automatic push_user();
    model.regs[8'h30] = 8'h00;
    model.regs[8'h31] = 8'hC3;
    run_op(8'h82, 8'h30, 8'h31, 0, 1'b0, 2'h3, 8'h30, 8'hFF);
    model.regs[8'h00] = 8'h03;
    model.regs[8'h01] = 8'h05;
    run_op(8'h83, 8'h00, 8'h01, 0, 1'b0, 2'h3, 8'h00, 8'h04);
    @(posedge clock);
    #1;
    chk("push dec ptr", 16'h00FF, rd(8'h30));
    chk("push dec dst", 16'h00C3, rd(8'hFF));
    chk("push inc ptr", 16'h0004, rd(8'h00));
    chk("push inc dst", 16'h0005, rd(8'h04));
  endtask

  task automatic push_system();
    model.regs[8'hD8] = 8'h00;
    model.regs[8'hD9] = 8'h00;
    model.regs[8'h40] = 8'h4F;
    model.regs[8'h4F] = 8'hAA;
    run_op(8'h70, 8'h40, 8'h00, 0, 1'b0, 2'h2, 8'hD9, 8'hD8);
    @(posedge clock);
    #1;
    chk("stack addr", 16'hFFFF, model.stk_addr_seen);
    chk("stack data", 16'h004F, {8'h00, model.stk_data_seen});
    chk("ptr high", 16'h00FF, rd(8'hD8));
    chk("ptr low", 16'h00FF, rd(8'hD9));
    model.regs[8'hD8] = 8'h12;
    model.regs[8'hD9] = 8'h00;
    run_op(8'h71, 8'h40, 8'h00, 0, 1'b0, 2'h2, 8'hD9, 8'hD8);
    @(posedge clock);
    #1;
    chk("stack addr", 16'h11FF, model.stk_addr_seen);
    chk("stack data", 16'h00AA, {8'h00, model.stk_data_seen});
    chk("ptr high", 16'h0011, rd(8'hD8));
    chk("stack writes", 16'h0002, 16'(model.stk_writes));
  endtask

  task automatic illegal_ignored();
    int busy_seen;
    busy_seen = 0;
    wr_log.delete();
    opcode = 8'h50;
    start = 1'b1;
    @(posedge clock);
    #1;
    start = 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1;
      busy_seen += (busy !== 1'b0);
    end
    chk("busy on illegal", 16'h0000, 16'(busy_seen));
    chk("writes on illegal", 16'h0000, 16'(wr_log.size()));
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    pop_dec_with_busy_start();
    pop_inc_wrap_stall();
    push_user();
    push_system();
    illegal_ignored();
    test_done();
  end
endmodule
`default_nettype wire

// ### rtl/ptr_step.sv
// Pointer increment or decrement that wraps within its own width.
`default_nettype none
module ptr_step #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] value,
  input  wire logic         dec,
  output logic      [W-1:0] result
);
  assign result = dec ? (value - W'(1)) : (value + W'(1));
endmodule
`default_nettype wire

// ### rtl/stack_exec_pkg.sv
// Constants and types shared by the stack instruction execution logic.
`default_nettype none
package stack_exec_pkg;
  localparam logic [7:0] OPC_USER_POP_DEC  = 8'h92;
  localparam logic [7:0] OPC_USER_POP_INC  = 8'h93;
  localparam logic [7:0] OPC_PUSH_DIRECT   = 8'h70;
  localparam logic [7:0] OPC_PUSH_INDIRECT = 8'h71;
  localparam logic [7:0] OPC_USER_PUSH_DEC = 8'h82;
  localparam logic [7:0] OPC_USER_PUSH_INC = 8'h83;
  localparam logic [7:0] STACK_PTR_HIGH_ADDR = 8'hD8;
  localparam logic [7:0] STACK_PTR_LOW_ADDR  = 8'hD9;
  localparam logic [1:0] USER_INSTR_BYTES = 2'h3;
  localparam logic [1:0] PUSH_INSTR_BYTES = 2'h2;
  localparam int         EXEC_CYCLES = 8;
  localparam logic [2:0] LAST_STEP   = 3'(EXEC_CYCLES - 1);
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_t;
endpackage
`default_nettype wire

// ### rtl/stack_push_pop_exec.sv
// Sequencer for system push and the four user-stack instructions.
// Function
// - Pop decrement: copy first, then lower pointer.
// - Opcode 92: three bytes, eight cycles.
// - Pop increment: copy first, then raise pointer.
// - Opcode 93: three bytes, eight cycles.
// - System push: lower pointer, then write stack.
// - Opcode 70: direct source, two bytes, eight cycles.
// - Opcode 71: indirect source, eight cycles.
// - Stack pointer is one 16-bit wrapping value.
// - Push decrement: lower pointer, then write.
// - Opcode 82: three bytes, eight cycles.
// - Push increment: raise pointer, then write.
// - Opcode 83: three bytes, eight cycles.
// - No status flag is ever changed.
// - User pointer is a register-file register.
// - Stack pointer bytes live at D8, D9.
`default_nettype none
module stack_push_pop_exec (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  opnd1,
  input  wire logic [7:0]  opnd2,
  output logic             busy,
  output logic             done,
  output logic [1:0]       instr_bytes,
  output logic [7:0]       rf_raddr,
  input  wire logic [7:0]  rf_rdata,
  output logic             rf_we,
  output logic [7:0]       rf_waddr,
  output logic [7:0]       rf_wdata,
  output logic             stk_we,
  output logic [15:0]      stk_addr,
  output logic [7:0]       stk_wdata,
  output logic             flags_we
);
  logic rst_meta_ff;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n  <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  stack_exec_pkg::exec_state_t state_ff, nxt_state;
  logic [2:0]  step_ff, nxt_step;
  logic [7:0]  opc_ff, nxt_opc;
  logic [7:0]  op1_ff, nxt_op1;
  logic [7:0]  op2_ff, nxt_op2;
  logic [7:0]  ptr_ff, nxt_ptr;
  logic [7:0]  data_ff, nxt_data;
  logic [15:0] sp_ff, nxt_sp;
  logic [1:0]  bytes_ff, nxt_bytes;
  logic [7:0]  raddr_ff, nxt_raddr;
  logic        we_ff, nxt_we;
  logic [7:0]  waddr_ff, nxt_waddr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        stk_we_ff, nxt_stk_we;
  logic [15:0] stk_addr_ff, nxt_stk_addr;
  logic [7:0]  stk_wdata_ff, nxt_stk_wdata;
  logic        done_ff, nxt_done;

  logic        is_pop;
  logic        is_pushu;
  logic        is_dec;
  logic        is_ind;
  logic        legal;
  logic [7:0]  ptr_new;
  logic [15:0] sp_new;

  assign is_pop   = (opc_ff == stack_exec_pkg::OPC_USER_POP_DEC) ||
                    (opc_ff == stack_exec_pkg::OPC_USER_POP_INC);
  assign is_pushu = (opc_ff == stack_exec_pkg::OPC_USER_PUSH_DEC) ||
                    (opc_ff == stack_exec_pkg::OPC_USER_PUSH_INC);
  assign is_dec   = (opc_ff == stack_exec_pkg::OPC_USER_POP_DEC) ||
                    (opc_ff == stack_exec_pkg::OPC_USER_PUSH_DEC);
  assign is_ind   = (opc_ff == stack_exec_pkg::OPC_PUSH_INDIRECT);
  assign legal    = (opcode == stack_exec_pkg::OPC_USER_POP_DEC) ||
                    (opcode == stack_exec_pkg::OPC_USER_POP_INC) ||
                    (opcode == stack_exec_pkg::OPC_USER_PUSH_DEC) ||
                    (opcode == stack_exec_pkg::OPC_USER_PUSH_INC) ||
                    (opcode == stack_exec_pkg::OPC_PUSH_DIRECT) ||
                    (opcode == stack_exec_pkg::OPC_PUSH_INDIRECT);

  ptr_step #(.W(8)) u_user_step (
    .value  (ptr_ff),
    .dec    (is_dec),
    .result (ptr_new)
  );

  ptr_step #(.W(16)) u_sys_step (
    .value  (sp_ff),
    .dec    (1'b1),
    .result (sp_new)
  );

  // The register file read is asynchronous on the registered address, so a
  // read issued in one step is captured in the next; this keeps every bus
  // output on a flip-flop at the price of one step per read.
  always_comb begin
    nxt_state     = state_ff;
    nxt_step      = step_ff;
    nxt_opc       = opc_ff;
    nxt_op1       = op1_ff;
    nxt_op2       = op2_ff;
    nxt_ptr       = ptr_ff;
    nxt_data      = data_ff;
    nxt_sp        = sp_ff;
    nxt_bytes     = bytes_ff;
    nxt_raddr     = raddr_ff;
    nxt_we        = 1'b0;
    nxt_waddr     = waddr_ff;
    nxt_wdata     = wdata_ff;
    nxt_stk_we    = 1'b0;
    nxt_stk_addr  = stk_addr_ff;
    nxt_stk_wdata = stk_wdata_ff;
    nxt_done      = 1'b0;
    unique case (state_ff)
      stack_exec_pkg::ST_IDLE: begin
        // Opcodes outside this block are ignored and never make it busy.
        if (start && legal) begin
          nxt_state = stack_exec_pkg::ST_EXEC;
          nxt_step  = 3'h0;
          nxt_opc   = opcode;
          nxt_op1   = opnd1;
          nxt_op2   = opnd2;
          nxt_bytes = ((opcode == stack_exec_pkg::OPC_PUSH_DIRECT) ||
                       (opcode == stack_exec_pkg::OPC_PUSH_INDIRECT)) ?
                      stack_exec_pkg::PUSH_INSTR_BYTES : stack_exec_pkg::USER_INSTR_BYTES;
        end
      end
      stack_exec_pkg::ST_EXEC: begin
        nxt_step = step_ff + 3'h1;
        if (step_ff == stack_exec_pkg::LAST_STEP) begin
          nxt_state = stack_exec_pkg::ST_IDLE;
          nxt_done  = 1'b1;
        end
        if (is_pop || is_pushu) begin
          unique case (step_ff)
            3'h0: nxt_raddr = op1_ff;
            3'h1: begin
              nxt_ptr   = rf_rdata;
              nxt_raddr = is_pop ? rf_rdata : op2_ff;
            end
            3'h2: nxt_data = rf_rdata;
            3'h3: begin
              nxt_we    = 1'b1;
              nxt_waddr = is_pop ? op2_ff : op1_ff;
              nxt_wdata = is_pop ? data_ff : ptr_new;
            end
            3'h4: begin
              nxt_we    = 1'b1;
              nxt_waddr = is_pop ? op1_ff : ptr_new;
              nxt_wdata = is_pop ? ptr_new : data_ff;
            end
            default: ;
          endcase
        end else begin
          unique case (step_ff)
            3'h0: nxt_raddr = op1_ff;
            3'h1: begin
              if (is_ind) begin
                nxt_ptr   = rf_rdata;
                nxt_raddr = rf_rdata;
              end else begin
                nxt_data  = rf_rdata;
                nxt_raddr = stack_exec_pkg::STACK_PTR_HIGH_ADDR;
              end
            end
            3'h2: begin
              if (is_ind) begin
                nxt_data  = rf_rdata;
                nxt_raddr = stack_exec_pkg::STACK_PTR_HIGH_ADDR;
              end else begin
                nxt_sp[15:8] = rf_rdata;
                nxt_raddr    = stack_exec_pkg::STACK_PTR_LOW_ADDR;
              end
            end
            3'h3: begin
              if (is_ind) begin
                nxt_sp[15:8] = rf_rdata;
                nxt_raddr    = stack_exec_pkg::STACK_PTR_LOW_ADDR;
              end else begin
                nxt_sp[7:0] = rf_rdata;
              end
            end
            3'h4: begin
              if (is_ind) begin
                nxt_sp[7:0] = rf_rdata;
              end
            end
            3'h5: begin
              nxt_we    = 1'b1;
              nxt_waddr = stack_exec_pkg::STACK_PTR_LOW_ADDR;
              nxt_wdata = sp_new[7:0];
            end
            3'h6: begin
              nxt_we    = 1'b1;
              nxt_waddr = stack_exec_pkg::STACK_PTR_HIGH_ADDR;
              nxt_wdata = sp_new[15:8];
            end
            3'h7: begin
              nxt_stk_we    = 1'b1;
              nxt_stk_addr  = sp_new;
              nxt_stk_wdata = data_ff;
            end
            default: ;
          endcase
        end
      end
      default: nxt_state = stack_exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff     <= stack_exec_pkg::ST_IDLE;
      step_ff      <= 3'h0;
      opc_ff       <= stack_exec_pkg::BYTE_RESET;
      op1_ff       <= stack_exec_pkg::BYTE_RESET;
      op2_ff       <= stack_exec_pkg::BYTE_RESET;
      ptr_ff       <= stack_exec_pkg::BYTE_RESET;
      data_ff      <= stack_exec_pkg::BYTE_RESET;
      sp_ff        <= stack_exec_pkg::WORD_RESET;
      bytes_ff     <= 2'h0;
      raddr_ff     <= stack_exec_pkg::BYTE_RESET;
      we_ff        <= 1'b0;
      waddr_ff     <= stack_exec_pkg::BYTE_RESET;
      wdata_ff     <= stack_exec_pkg::BYTE_RESET;
      stk_we_ff    <= 1'b0;
      stk_addr_ff  <= stack_exec_pkg::WORD_RESET;
      stk_wdata_ff <= stack_exec_pkg::BYTE_RESET;
      done_ff      <= 1'b0;
    end else if (ce) begin
      state_ff     <= nxt_state;
      step_ff      <= nxt_step;
      opc_ff       <= nxt_opc;
      op1_ff       <= nxt_op1;
      op2_ff       <= nxt_op2;
      ptr_ff       <= nxt_ptr;
      data_ff      <= nxt_data;
      sp_ff        <= nxt_sp;
      bytes_ff     <= nxt_bytes;
      raddr_ff     <= nxt_raddr;
      we_ff        <= nxt_we;
      waddr_ff     <= nxt_waddr;
      wdata_ff     <= nxt_wdata;
      stk_we_ff    <= nxt_stk_we;
      stk_addr_ff  <= nxt_stk_addr;
      stk_wdata_ff <= nxt_stk_wdata;
      done_ff      <= nxt_done;
    end
  end

  assign busy        = (state_ff == stack_exec_pkg::ST_EXEC);
  assign done        = done_ff;
  assign instr_bytes = bytes_ff;
  assign rf_raddr    = raddr_ff;
  assign rf_we       = we_ff;
  assign rf_waddr    = waddr_ff;
  assign rf_wdata    = wdata_ff;
  assign stk_we      = stk_we_ff;
  assign stk_addr    = stk_addr_ff;
  assign stk_wdata   = stk_wdata_ff;
  assign flags_we    = 1'b0;

  logic accept;
  assign accept = ce && start && legal && (state_ff == stack_exec_pkg::ST_IDLE);

  property p_done_len;
    @(posedge clock) disable iff (!rst_sync_n)
    accept ##1 ce [*8] |=> done_ff;
  endproperty
  a_done_len: assert property (p_done_len) else $error("done not after eight steps");

  property p_pop_dec_order;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && opc_ff == stack_exec_pkg::OPC_USER_POP_DEC && step_ff == 3'h3) |=>
      (we_ff && waddr_ff == op2_ff && wdata_ff == data_ff) ##1
      (we_ff && waddr_ff == op1_ff && wdata_ff == 8'(ptr_ff - 8'h01));
  endproperty
  a_pop_dec_order: assert property (p_pop_dec_order) else $error("pop dec order wrong");

  property p_pop_inc_order;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && opc_ff == stack_exec_pkg::OPC_USER_POP_INC && step_ff == 3'h3) |=>
      (we_ff && waddr_ff == op2_ff) ##1
      (we_ff && waddr_ff == op1_ff && wdata_ff == 8'(ptr_ff + 8'h01));
  endproperty
  a_pop_inc_order: assert property (p_pop_inc_order) else $error("pop inc order wrong");

  property p_push_dec_order;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && opc_ff == stack_exec_pkg::OPC_USER_PUSH_DEC && step_ff == 3'h3) |=>
      (we_ff && waddr_ff == op1_ff && wdata_ff == 8'(ptr_ff - 8'h01)) ##1
      (we_ff && waddr_ff == 8'(ptr_ff - 8'h01) && wdata_ff == data_ff);
  endproperty
  a_push_dec_order: assert property (p_push_dec_order) else $error("push dec order wrong");

  property p_push_inc_order;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && opc_ff == stack_exec_pkg::OPC_USER_PUSH_INC && step_ff == 3'h3) |=>
      (we_ff && waddr_ff == op1_ff) ##1
      (we_ff && waddr_ff == 8'(ptr_ff + 8'h01) && wdata_ff == data_ff);
  endproperty
  a_push_inc_order: assert property (p_push_inc_order) else $error("push inc order wrong");

  property p_pop_indirect;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && is_pop && step_ff == 3'h1) |->
      (rf_raddr == op1_ff) ##1 (rf_raddr == $past(rf_rdata) && rf_raddr == ptr_ff);
  endproperty
  a_pop_indirect: assert property (p_pop_indirect) else $error("pop not via pointer");

  property p_sp_wrap;
    @(posedge clock) disable iff (!rst_sync_n)
    $rose(stk_we_ff) |-> (stk_addr_ff == 16'(sp_ff - 16'h0001));
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("stack address not sp minus one");

  property p_sp_map;
    @(posedge clock) disable iff (!rst_sync_n || !ce)
    (busy && !is_pop && !is_pushu && step_ff == 3'h5) |=>
      (we_ff && waddr_ff == stack_exec_pkg::STACK_PTR_LOW_ADDR) ##1
      (we_ff && waddr_ff == stack_exec_pkg::STACK_PTR_HIGH_ADDR) ##1
      (stk_we_ff && !we_ff);
  endproperty
  a_sp_map: assert property (p_sp_map) else $error("stack pointer update order wrong");

  property p_no_flags;
    @(posedge clock) disable iff (!rst_sync_n)
    busy |-> !flags_we;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flags written");

  c_pop:  cover property (@(posedge clock) disable iff (!rst_sync_n)
    (busy && is_pop) ##[1:8] done_ff);
  c_push: cover property (@(posedge clock) disable iff (!rst_sync_n) stk_we_ff && is_ind);
  c_wrap: cover property (@(posedge clock) disable iff (!rst_sync_n) stk_we_ff && stk_addr_ff == 16'hFFFF);
  c_pushu: cover property (@(posedge clock) disable iff (!rst_sync_n) busy && is_pushu && we_ff);
endmodule
`default_nettype wire
